// ---- mfl_fault_latch.sv ----
// one fault flag with latched or self-clearing behaviour
`timescale 1ns/1ns
`default_nettype none
module mfl_fault_latch (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // control
    input wire logic i_cond,
    input wire logic i_auto_clear,
    input wire logic i_sw_clear,
    // state
    output logic o_fault,
    output logic o_event
);
    logic fault_ff;
    logic cond_d_ff;
    // a present condition always wins over any clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fault_ff <= 1'b0;
        end else if (i_cond) begin
            fault_ff <= 1'b1;
        end else if (i_auto_clear || i_sw_clear) begin
            fault_ff <= 1'b0;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cond_d_ff <= 1'b0;
        end else begin
            cond_d_ff <= i_cond;
        end
    end
    assign o_fault = fault_ff;
    assign o_event = i_cond && !cond_d_ff;
endmodule : mfl_fault_latch
`default_nettype wire

// ---- mfl_fault_limit.sv ----
// fault limit configuration register and the fault supervision it steers
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - bit 26 enables the overspeed lock detector
// - bit 25 enables the invalid hall code lock detector
// - bit 24 enables the open winding lock detector
// - bits 23:21 pick overspeed limit, 130% plus 10% per code
// - bits 17:13 pick open winding current threshold from table
// - bits 7:5 pick undervoltage limit; code 0 means no limit
// - bit 4: undervoltage fault latches at 0, self-clears at 1
// - bits 3:1 pick overvoltage limit 60..90%, code 7 maximum
// - bit 0: overvoltage fault latches at 0, self-clears at 1
// - register at offset 54h, resets to all zeros
// - lock mode: latch with fault pin, retry clear, report only, off
module mfl_fault_limit
    import mfl_pkg::*;
#(
    parameter int CYC_MS = mfl_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [mfl_pkg::ADDR_W-1:0] i_addr,
    input wire logic [mfl_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [mfl_pkg::DATA_W-1:0] o_rdata,
    // measurements in tenths of a percent of full scale, hall code and run flag
    input wire logic [11:0] i_speed_pm,
    input wire logic [11:0] i_current_pm,
    input wire logic [11:0] i_voltage_pm,
    input wire logic [2:0] i_hall,
    input wire logic i_running,
    // decoded limits for neighbouring logic
    output logic [11:0] o_os_limit,
    output logic [11:0] o_ow_limit,
    output logic [11:0] o_uv_limit,
    output logic [11:0] o_ov_limit,
    // fault outputs
    output logic o_lock_fault,
    output logic o_uv_fault,
    output logic o_ov_fault,
    output logic o_fault_output_n,
    output logic o_irq
);
    import mfl_pkg::*;

    logic [31:0] cfg_ff;
    logic [31:0] lock_cfg_ff;
    logic [NUM_EV-1:0] irq_stat_ff;
    logic [NUM_EV-1:0] irq_en_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [2:0] hall_s1_ff;
    logic [2:0] hall_s2_ff;
    logic overspeed_detect_enable;
    logic hall_detect_enable;
    logic open_winding_detect_enable;
    logic [2:0] overspeed_threshold_select;
    logic [4:0] open_winding_current_threshold;
    logic [2:0] undervoltage_threshold_select;
    logic undervoltage_recovery_mode;
    logic [2:0] overvoltage_threshold_select;
    logic overvoltage_recovery_mode;
    mfl_lock_mode_e lock_response_mode;
    logic [15:0] retry_ms;
    logic os_hit;
    logic hall_hit;
    logic ow_hit;
    logic uv_hit;
    logic ov_hit;
    logic lock_hit;
    logic lock_run;
    logic retry_done;
    logic lock_clr;
    logic uv_ev;
    logic ov_ev;
    logic lock_ev;
    logic [NUM_EV-1:0] events;
    logic wr_clear;

    // field decode
    assign overspeed_detect_enable = cfg_ff[POS_OVERSPEED_EN];
    assign hall_detect_enable = cfg_ff[POS_HALL_EN];
    assign open_winding_detect_enable = cfg_ff[POS_OPEN_WIND_EN];
    assign overspeed_threshold_select = cfg_ff[POS_OS_THR +: 3];
    assign open_winding_current_threshold = cfg_ff[POS_OW_THR +: 5];
    assign undervoltage_threshold_select = cfg_ff[POS_UV_THR +: 3];
    assign undervoltage_recovery_mode = cfg_ff[POS_UV_MODE];
    assign overvoltage_threshold_select = cfg_ff[POS_OV_THR +: 3];
    assign overvoltage_recovery_mode = cfg_ff[POS_OV_MODE];
    assign lock_response_mode = mfl_lock_mode_e'(lock_cfg_ff[1:0]);
    // retry time taken in milliseconds from a neighbouring field
    assign retry_ms = lock_cfg_ff[17:2];

    assign o_os_limit = os_thr_pm(overspeed_threshold_select);
    assign o_ow_limit = ow_thr_pm(open_winding_current_threshold);
    assign o_uv_limit = uv_thr_pm(undervoltage_threshold_select);
    assign o_ov_limit = ov_thr_pm(overvoltage_threshold_select);

    // hall pins are asynchronous to this clock
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hall_s1_ff <= 3'h1;
            hall_s2_ff <= 3'h1;
        end else begin
            hall_s1_ff <= i_hall;
            hall_s2_ff <= hall_s1_ff;
        end
    end

    // detectors
    assign os_hit = overspeed_detect_enable && (i_speed_pm > o_os_limit);
    assign hall_hit = hall_detect_enable && (hall_s2_ff == 3'h0 || hall_s2_ff == 3'h7);
    assign ow_hit = open_winding_detect_enable && i_running
        && (i_current_pm < o_ow_limit);
    // code 0 means no undervoltage limit, so the compare never fires
    assign uv_hit = (undervoltage_threshold_select != 3'h0)
        && (i_voltage_pm < o_uv_limit);
    // code 7 limit is all ones, so no 12-bit reading, even a saturated one, can trip
    assign ov_hit = (i_voltage_pm > o_ov_limit);
    assign lock_hit = (os_hit || hall_hit || ow_hit)
        && (lock_response_mode != MFL_LOCK_OFF);

    // register writes
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_ff <= RST_FAULT_LIMIT_CONFIG;
        end else if (i_wr && i_addr == OFS_FAULT_LIMIT_CONFIG) begin
            cfg_ff <= i_wdata & CFG_WRITE_MASK;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_cfg_ff <= RST_LOCK_CONFIG;
        end else if (i_wr && i_addr == OFS_LOCK_CONFIG) begin
            lock_cfg_ff <= i_wdata;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_en_ff <= RST_IRQ[NUM_EV-1:0];
        end else if (i_wr && i_addr == OFS_IRQ_ENABLE) begin
            irq_en_ff <= i_wdata[NUM_EV-1:0];
        end
    end
    assign wr_clear = i_wr && (i_addr == OFS_FAULT_STATUS);

    // lock fault: report-only mode never holds a fault
    assign lock_run = o_lock_fault && (lock_response_mode == MFL_LOCK_RETRY) && !lock_hit;
    assign lock_clr = (lock_response_mode == MFL_LOCK_REPORT)
        || (lock_response_mode == MFL_LOCK_OFF) || retry_done || wr_clear;

    mfl_retry_timer #(
        .CYC_MS(CYC_MS)
    ) u_retry (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_run(lock_run),
        .i_ms(retry_ms),
        .o_done(retry_done)
    );

    mfl_fault_latch u_lock (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_cond(lock_hit && lock_response_mode != MFL_LOCK_REPORT),
        .i_auto_clear(lock_clr),
        .i_sw_clear(1'b0),
        .o_fault(o_lock_fault),
        .o_event()
    );
    assign lock_ev = lock_hit && !o_lock_fault;

    mfl_fault_latch u_uv (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_cond(uv_hit),
        .i_auto_clear(undervoltage_recovery_mode),
        .i_sw_clear(wr_clear),
        .o_fault(o_uv_fault),
        .o_event(uv_ev)
    );

    mfl_fault_latch u_ov (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_cond(ov_hit),
        .i_auto_clear(overvoltage_recovery_mode),
        .i_sw_clear(wr_clear),
        .o_fault(o_ov_fault),
        .o_event(ov_ev)
    );

    // fault pin is low for a held lock or voltage fault
    assign o_fault_output_n = !(o_lock_fault || o_uv_fault || o_ov_fault);

    // interrupt status, set wins over clear
    assign events[EV_OVERSPEED] = os_hit && lock_ev;
    assign events[EV_HALL] = hall_hit && lock_ev;
    assign events[EV_OPEN_WIND] = ow_hit && lock_ev;
    assign events[EV_UV] = uv_ev;
    assign events[EV_OV] = ov_ev;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_stat_ff <= RST_IRQ[NUM_EV-1:0];
        end else if (i_wr && i_addr == OFS_IRQ_CLEAR) begin
            irq_stat_ff <= (irq_stat_ff & ~i_wdata[NUM_EV-1:0]) | events;
        end else begin
            irq_stat_ff <= irq_stat_ff | events;
        end
    end
    assign o_irq = |(irq_stat_ff & irq_en_ff);

    // read data, one cycle after the strobe and only then
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (i_rd) begin
            unique case (i_addr)
                OFS_FAULT_LIMIT_CONFIG: nxt_rdata = cfg_ff;
                OFS_LOCK_CONFIG: nxt_rdata = lock_cfg_ff;
                OFS_IRQ_STATUS: nxt_rdata = {27'h0, irq_stat_ff};
                OFS_IRQ_ENABLE: nxt_rdata = {27'h0, irq_en_ff};
                OFS_FAULT_STATUS: nxt_rdata = {29'h0, o_ov_fault, o_uv_fault, o_lock_fault};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_rdata = rdata_ff;

    // assertions
    reset_value_a: assert property (@(posedge i_ref_clk) $rose(i_nrst) |-> cfg_ff == 32'h0)
        else $error("config not zero after reset");
    reserved_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        cfg_ff[20:18] == 3'h0) else $error("reserved bits not zero");
    os_enable_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !cfg_ff[26] |-> !os_hit) else $error("overspeed hit while disabled");
    hall_enable_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !cfg_ff[25] |-> !hall_hit) else $error("hall hit while disabled");
    ow_enable_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !cfg_ff[24] |-> !ow_hit) else $error("open winding hit while disabled");
    os_limit_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_os_limit == 12'(1300 + 100 * int'(cfg_ff[23:21]))) else $error("overspeed limit wrong");
    ow_ends_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (cfg_ff[17:13] == 5'h1f |-> o_ow_limit == 12'd1000)
        and (cfg_ff[17:13] == 5'h0f |-> o_ow_limit == 12'd225))
        else $error("open winding limit wrong");
    uv_nolimit_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        cfg_ff[7:5] == 3'h0 |-> !uv_hit) else $error("undervoltage with no limit");
    uv_latch_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_uv_fault && !cfg_ff[4] && !wr_clear |=> o_uv_fault) else $error("uv latch lost");
    ov_limit_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        cfg_ff[3:1] == 3'h2 |-> o_ov_limit == 12'd700) else $error("overvoltage limit wrong");
    ov_auto_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_ov_fault && cfg_ff[0] && !ov_hit |=> !o_ov_fault) else $error("ov auto clear failed");
    lock_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        lock_hit && lock_response_mode == MFL_LOCK_LATCH |=> o_lock_fault && !o_fault_output_n)
        else $error("lock did not raise fault");
    uv_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        uv_hit |=> o_uv_fault)
        else $error("uv fault not set");
    uv_auto_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_uv_fault && cfg_ff[POS_UV_MODE] && !uv_hit |=> !o_uv_fault)
        else $error("uv auto clear failed");
    ov_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        ov_hit |=> o_ov_fault)
        else $error("ov fault not set");
    ov_latch_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_ov_fault && !cfg_ff[POS_OV_MODE] && !wr_clear |=> o_ov_fault)
        else $error("ov latch lost");
    cfg_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_wr && i_addr == OFS_FAULT_LIMIT_CONFIG
        |=> cfg_ff == ($past(i_wdata) & CFG_WRITE_MASK))
        else $error("config write wrong");
    cfg_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_rd && i_addr == OFS_FAULT_LIMIT_CONFIG |=> o_rdata == $past(cfg_ff))
        else $error("config read wrong");
    report_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        lock_response_mode == MFL_LOCK_REPORT |=> !o_lock_fault)
        else $error("report mode held fault");
    off_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        lock_response_mode == MFL_LOCK_OFF |=> !o_lock_fault)
        else $error("off mode held fault");
    os_trip_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        overspeed_detect_enable && i_speed_pm > o_os_limit
        && lock_response_mode == MFL_LOCK_LATCH |=> o_lock_fault)
        else $error("overspeed did not trip");
    hall_bad_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        hall_detect_enable && hall_s2_ff == 3'h0
        && lock_response_mode == MFL_LOCK_LATCH |=> o_lock_fault)
        else $error("hall code did not trip");
    ow_trip_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        open_winding_detect_enable && i_running && i_current_pm < o_ow_limit
        && lock_response_mode == MFL_LOCK_LATCH |=> o_lock_fault)
        else $error("open winding did not trip");
endmodule : mfl_fault_limit
`default_nettype wire

// ---- mfl_pkg.sv ----
// package: register map, field layout and threshold tables of the fault limit configuration
package mfl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_FAULT_LIMIT_CONFIG = 8'h54;
    localparam logic [7:0] OFS_LOCK_CONFIG = 8'h50;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h74;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h78;
    localparam logic [7:0] OFS_FAULT_STATUS = 8'h7c;
    // field positions in fault_limit_config
    localparam int POS_OVERSPEED_EN = 26;
    localparam int POS_HALL_EN = 25;
    localparam int POS_OPEN_WIND_EN = 24;
    localparam int POS_OS_THR = 21;
    localparam int POS_OW_THR = 13;
    localparam int POS_UV_THR = 5;
    localparam int POS_UV_MODE = 4;
    localparam int POS_OV_THR = 1;
    localparam int POS_OV_MODE = 0;
    // reserved bits 20..18 read zero; all others are storage
    localparam logic [31:0] CFG_WRITE_MASK = 32'hffe3ffff;
    localparam logic [31:0] RST_FAULT_LIMIT_CONFIG = 32'h00000000;
    localparam logic [31:0] RST_LOCK_CONFIG = 32'h00000000;
    localparam logic [31:0] RST_IRQ = 32'h00000000;
    // lock response modes
    typedef enum logic [1:0] {
        MFL_LOCK_LATCH = 2'h0,
        MFL_LOCK_RETRY = 2'h1,
        MFL_LOCK_REPORT = 2'h2,
        MFL_LOCK_OFF = 2'h3
    } mfl_lock_mode_e;
    // interrupt event bits
    localparam int EV_OVERSPEED = 0;
    localparam int EV_HALL = 1;
    localparam int EV_OPEN_WIND = 2;
    localparam int EV_UV = 3;
    localparam int EV_OV = 4;
    localparam int NUM_EV = 5;
    // retry time unit (ms) and cycles per ms at 125 MHz
    localparam int CLK_HZ = 125000000;
    localparam int RETRY_UNIT_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / 1000 * RETRY_UNIT_MS;
    // percent thresholds in tenths of a percent of full scale
    function automatic logic [11:0] os_thr_pm(input logic [2:0] code);
        os_thr_pm = 12'(1300 + 100 * int'(code));
    endfunction : os_thr_pm
    function automatic logic [11:0] uv_thr_pm(input logic [2:0] code);
        unique case (code)
            3'h0: uv_thr_pm = 12'h000;
            3'h1: uv_thr_pm = 12'd50;
            3'h2: uv_thr_pm = 12'd100;
            3'h3: uv_thr_pm = 12'd120;
            3'h4: uv_thr_pm = 12'd150;
            3'h5: uv_thr_pm = 12'd180;
            3'h6: uv_thr_pm = 12'd200;
            default: uv_thr_pm = 12'd250;
        endcase
    endfunction : uv_thr_pm
    function automatic logic [11:0] ov_thr_pm(input logic [2:0] code);
        ov_thr_pm = (code == 3'h7) ? 12'hfff : 12'(600 + 50 * int'(code));
    endfunction : ov_thr_pm
    function automatic logic [11:0] ow_thr_pm(input logic [4:0] code);
        logic [11:0] t;
        t = 12'h000;
        if (code <= 5'h04) begin
            t = 12'(75 + 5 * int'(code));
        end else if (code <= 5'h0d) begin
            t = 12'(50 + 10 * int'(code));
        end else if (code <= 5'h12) begin
            t = 12'(200 + 25 * (int'(code) - 14));
        end else if (code <= 5'h18) begin
            t = 12'(350 + 50 * (int'(code) - 19));
        end else begin
            t = 12'(700 + 50 * (int'(code) - 25));
        end
        ow_thr_pm = t;
    endfunction : ow_thr_pm
endpackage : mfl_pkg

// ---- mfl_retry_timer.sv ----
// retry timer for self-clearing lock faults, ticking on a millisecond enable
`timescale 1ns/1ns
`default_nettype none
module mfl_retry_timer #(
    parameter int CYC_MS = mfl_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // control
    input wire logic i_run,
    input wire logic [15:0] i_ms,
    // result
    output logic o_done
);
    logic [16:0] div_ff;
    logic [15:0] ms_ff;
    logic tick;
    assign tick = (div_ff == 17'(CYC_MS - 1));
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_ff <= '0;
        end else if (!i_run || tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 17'h1;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ms_ff <= '0;
        end else if (!i_run) begin
            ms_ff <= '0;
        end else if (tick && ms_ff != i_ms) begin
            ms_ff <= ms_ff + 16'h1;
        end
    end
    assign o_done = i_run && (ms_ff == i_ms);
endmodule : mfl_retry_timer
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench of the fault limit configuration register
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import mfl_pkg::*;
    // short millisecond tick keeps retry runs brief
    localparam int CYC = 4;
    logic i_ref_clk, i_nrst, i_wr, i_rd, i_running;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [11:0] i_speed_pm, i_current_pm, i_voltage_pm;
    logic [2:0] i_hall;
    logic [11:0] o_os_limit, o_ow_limit, o_uv_limit, o_ov_limit;
    logic o_lock_fault, o_uv_fault, o_ov_fault, o_fault_output_n, o_irq;
    int mismatches = 0;
    int checks = 0;
    int ow_tab[32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160, 170, 180, 200,
        225, 250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850, 900, 950, 1000};
    int uv_tab[8] = '{0, 50, 100, 120, 150, 180, 200, 250};

    mfl_fault_limit #(.CYC_MS(CYC)) mfl_fault_limit_inst (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_speed_pm(i_speed_pm),
        .i_current_pm(i_current_pm), .i_voltage_pm(i_voltage_pm), .i_hall(i_hall),
        .i_running(i_running), .o_os_limit(o_os_limit), .o_ow_limit(o_ow_limit),
        .o_uv_limit(o_uv_limit), .o_ov_limit(o_ov_limit), .o_lock_fault(o_lock_fault),
        .o_uv_fault(o_uv_fault), .o_ov_fault(o_ov_fault),
        .o_fault_output_n(o_fault_output_n), .o_irq(o_irq)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // strobe raised after one edge, dropped after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd

    // hall input passes a two-flop synchroniser, so allow a few cycles
    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : settle

    task automatic t_reset();
        rd(OFS_FAULT_LIMIT_CONFIG, d);
        chk("cfg_reset", d, RST_FAULT_LIMIT_CONFIG);
        chk("fault_n_reset", 32'(o_fault_output_n), 32'h1);
        chk("uv_limit_reset", 32'(o_uv_limit), 32'h0);
        chk("ov_limit_reset", 32'(o_ov_limit), 32'd600);
        $display("test reset done");
    endtask : t_reset

    task automatic t_mask();
        wr(OFS_FAULT_LIMIT_CONFIG, 32'hffffffff);
        rd(OFS_FAULT_LIMIT_CONFIG, d);
        chk("cfg_mask", d, 32'hffe3ffff);
        wr(8'h04, 32'hdeadbeef);
        rd(8'h04, d);
        chk("unmapped_read", d, 32'h0);
        rd(OFS_FAULT_LIMIT_CONFIG, d);
        chk("cfg_kept", d, 32'hffe3ffff);
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h0);
        rd(OFS_FAULT_LIMIT_CONFIG, d);
        chk("cfg_zero", d, 32'h0);
        $display("test mask done");
    endtask : t_mask

    task automatic t_limits();
        for (int c = 0; c < 8; c++) begin
            wr(OFS_FAULT_LIMIT_CONFIG, (32'(c) << 21) | (32'(c) << 5) | (32'(c) << 1));
            chk("os_limit", 32'(o_os_limit), 32'(1300 + 100 * c));
            chk("uv_limit", 32'(o_uv_limit), 32'(uv_tab[c]));
            chk("ov_limit", 32'(o_ov_limit), (c == 7) ? 32'hfff : 32'(600 + 50 * c));
        end
        for (int c = 0; c < 32; c++) begin
            wr(OFS_FAULT_LIMIT_CONFIG, 32'(c) << 13);
            chk("ow_limit", 32'(o_ow_limit), 32'(ow_tab[c]));
        end
        $display("test limits done");
    endtask : t_limits

    task automatic t_uv();
        wr(OFS_IRQ_ENABLE, 32'h8);
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h1 << 5);
        i_voltage_pm <= 12'd40;
        settle(6);
        chk("uv_set", 32'(o_uv_fault), 32'h1);
        chk("uv_pin", 32'(o_fault_output_n), 32'h0);
        chk("uv_irq", 32'(o_irq), 32'h1);
        rd(OFS_IRQ_STATUS, d);
        chk("uv_status", d, 32'h8);
        rd(OFS_FAULT_STATUS, d);
        chk("uv_fault_status", d, 32'h2);
        i_voltage_pm <= 12'd500;
        settle(6);
        chk("uv_latched", 32'(o_uv_fault), 32'h1);
        wr(OFS_FAULT_STATUS, 32'h0);
        settle(2);
        chk("uv_cleared", 32'(o_uv_fault), 32'h0);
        wr(OFS_IRQ_CLEAR, 32'h8);
        chk("uv_irq_clr", 32'(o_irq), 32'h0);
        wr(OFS_FAULT_LIMIT_CONFIG, (32'h1 << 5) | 32'h10);
        i_voltage_pm <= 12'd40;
        settle(6);
        chk("uv_auto_set", 32'(o_uv_fault), 32'h1);
        i_voltage_pm <= 12'd50;
        settle(6);
        chk("uv_auto_clr", 32'(o_uv_fault), 32'h0);
        wr(OFS_IRQ_CLEAR, 32'hff);
        $display("test undervoltage done");
    endtask : t_uv

    task automatic t_ov();
        wr(OFS_IRQ_ENABLE, 32'h10);
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h2 << 1);
        i_voltage_pm <= 12'd701;
        settle(6);
        chk("ov_set", 32'(o_ov_fault), 32'h1);
        rd(OFS_IRQ_STATUS, d);
        chk("ov_status", d, 32'h10);
        rd(OFS_IRQ_ENABLE, d);
        chk("irq_en_read", d, 32'h10);
        i_voltage_pm <= 12'd700;
        settle(6);
        chk("ov_latched", 32'(o_ov_fault), 32'h1);
        wr(OFS_FAULT_STATUS, 32'h0);
        settle(2);
        chk("ov_cleared", 32'(o_ov_fault), 32'h0);
        wr(OFS_FAULT_LIMIT_CONFIG, (32'h2 << 1) | 32'h1);
        i_voltage_pm <= 12'd750;
        settle(6);
        chk("ov_auto_set", 32'(o_ov_fault), 32'h1);
        i_voltage_pm <= 12'd700;
        settle(6);
        chk("ov_auto_clr", 32'(o_ov_fault), 32'h0);
        i_voltage_pm <= 12'd500;
        wr(OFS_IRQ_CLEAR, 32'hff);
        $display("test overvoltage done");
    endtask : t_ov

    // each lock source: silent while disabled, held once enabled
    task automatic lock_pair(input logic [31:0] en, input string name);
        settle(6);
        chk({name, "_off"}, 32'(o_lock_fault), 32'h0);
        wr(OFS_FAULT_LIMIT_CONFIG, en);
        settle(6);
        chk({name, "_on"}, 32'(o_lock_fault), 32'h1);
        chk({name, "_pin"}, 32'(o_fault_output_n), 32'h0);
    endtask : lock_pair

    task automatic t_lock();
        wr(OFS_IRQ_ENABLE, 32'h7);
        // an enabled detector at exactly the limit must stay quiet
        wr(OFS_FAULT_LIMIT_CONFIG, (32'h7 << 21) | (32'h1 << 26));
        i_speed_pm <= 12'd2000;
        settle(6);
        chk("os_at_limit", 32'(o_lock_fault), 32'h0);
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h7 << 21);
        i_speed_pm <= 12'd2001;
        lock_pair((32'h7 << 21) | (32'h1 << 26), "overspeed");
        i_speed_pm <= 12'd0;
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h0);
        wr(OFS_FAULT_STATUS, 32'h0);
        i_hall <= 3'h0;
        lock_pair(32'h1 << 25, "hall");
        i_hall <= 3'h1;
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h0);
        wr(OFS_FAULT_STATUS, 32'h0);
        i_running <= 1'b1;
        i_current_pm <= 12'd70;
        lock_pair(32'h1 << 24, "open_wind");
        i_current_pm <= 12'd500;
        i_running <= 1'b0;
        wr(OFS_FAULT_STATUS, 32'h0);
        rd(OFS_IRQ_STATUS, d);
        chk("lock_status", d, 32'h7);
        wr(OFS_IRQ_CLEAR, 32'h7);
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h1 << 26);
        wr(OFS_LOCK_CONFIG, 32'h2);
        rd(OFS_LOCK_CONFIG, d);
        chk("lock_cfg_read", d, 32'h2);
        i_speed_pm <= 12'd2500;
        settle(6);
        chk("report_nohold", 32'(o_lock_fault), 32'h0);
        chk("report_pin", 32'(o_fault_output_n), 32'h1);
        rd(OFS_IRQ_STATUS, d);
        chk("report_status", d, 32'h1);
        // report mode keeps raising its event while speed is high, so leave it first
        wr(OFS_LOCK_CONFIG, 32'h3);
        wr(OFS_IRQ_CLEAR, 32'h7);
        settle(6);
        rd(OFS_IRQ_STATUS, d);
        chk("off_status", d, 32'h0);
        chk("off_nohold", 32'(o_lock_fault), 32'h0);
        wr(OFS_LOCK_CONFIG, 32'h1);
        settle(6);
        chk("retry_set", 32'(o_lock_fault), 32'h1);
        i_speed_pm <= 12'd0;
        settle(6);
        chk("retry_clr", 32'(o_lock_fault), 32'h0);
        // two-millisecond retry: still held after one tick, gone well after two
        wr(OFS_LOCK_CONFIG, (32'h2 << 2) | 32'h1);
        i_speed_pm <= 12'd2500;
        settle(6);
        chk("retry2_set", 32'(o_lock_fault), 32'h1);
        i_speed_pm <= 12'd0;
        settle(CYC);
        chk("retry2_hold", 32'(o_lock_fault), 32'h1);
        settle(3 * CYC);
        chk("retry2_clr", 32'(o_lock_fault), 32'h0);
        wr(OFS_LOCK_CONFIG, 32'h0);
        wr(OFS_FAULT_LIMIT_CONFIG, 32'h0);
        $display("test lock done");
    endtask : t_lock

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end

    initial begin
        i_nrst = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_speed_pm = 12'd0;
        i_current_pm = 12'd500;
        i_voltage_pm = 12'd500;
        i_hall = 3'h1;
        i_running = 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        t_reset();
        t_mask();
        t_limits();
        t_uv();
        t_ov();
        t_lock();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
